// ==== rtl/ibrl_fifo.sv ====
// small flip-flop buffer with valid/ready on both sides and a flush
`timescale 1ns/10ps
module ibrl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (count != FULL) & ~flush;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // ibrl_fifo

// ==== rtl/ibrl_msg_handler.sv ====
// remote/local, addressing, service request, poll, clear and trigger handling
`timescale 1ns/10ps
module ibrl_msg_handler #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [4:0] my_addr,
  input wire logic ren,
  input wire logic atn,
  input wire logic ifc,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] par_byte,
  output logic par_valid,
  input wire logic par_ready,
  input wire logic [7:0] resp_byte,
  input wire logic resp_valid,
  input wire logic resp_dashed,
  output logic resp_ready,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] status,
  input wire logic [7:0] sre,
  input wire logic key_valid,
  input wire logic key_is_local,
  output logic key_pass,
  input wire logic trig_wr,
  input wire logic [1:0] trig_in,
  input wire logic trg_cmd,
  output logic [1:0] trig_cfg,
  output logic meas_start,
  output logic dev_clear,
  output logic opc_idle,
  output logic remote_ind,
  output logic lockout,
  output logic listen_ind,
  output logic talk_ind,
  output logic srq,
  output logic ctrl_active
);
  ////////////////////////////////////////////////////////////////////////////////
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // parity bit 7 is ignored on every command
  function automatic logic cmd_hit(input logic [7:0] b, input logic [7:0] code);
    return b[6:0] == code[6:0];
  endfunction

  ibrl_pkg::ibrl_rl_t rl;
  ibrl_pkg::ibrl_rl_t next_rl;
  logic listen;
  logic talk;
  logic spoll;
  logic ren_q;
  logic rqs;
  logic tx_poll;
  logic [1:0] trig_saved;
  logic buf_in_ready;

  wire addr_ok = (my_addr != ibrl_pkg::ADDR_NONE); // [R23]
  wire [7:0] my_listen = ibrl_pkg::LISTEN_BASE | {3'h0, my_addr};
  wire [7:0] my_talk = ibrl_pkg::TALK_BASE | {3'h0, my_addr};
  wire cmd_take = rx_valid & atn;
  wire mla_ev = cmd_take & addr_ok & cmd_hit(rx_byte, my_listen);
  wire mta_ev = cmd_take & addr_ok & cmd_hit(rx_byte, my_talk);
  wire unl_ev = cmd_take & cmd_hit(rx_byte, ibrl_pkg::CMD_UNL);
  // any talk address, untalk included, that is not ours removes our talker role
  wire ota_ev = cmd_take & (rx_byte[6:5] == ibrl_pkg::TALK_GROUP) & ~mta_ev;
  wire gtl_ev = cmd_take & cmd_hit(rx_byte, ibrl_pkg::CMD_GTL) & listen;
  wire sdc_ev = cmd_take & cmd_hit(rx_byte, ibrl_pkg::CMD_SDC);
  wire dcl_ev = cmd_take & cmd_hit(rx_byte, ibrl_pkg::CMD_DCL);
  wire get_ev = cmd_take & cmd_hit(rx_byte, ibrl_pkg::CMD_GET);
  wire tct_ev = cmd_take & cmd_hit(rx_byte, ibrl_pkg::CMD_TCT);
  wire llo_ev = cmd_take & cmd_hit(rx_byte, ibrl_pkg::CMD_LLO);
  wire spe_ev = cmd_take & cmd_hit(rx_byte, ibrl_pkg::CMD_SPE);
  wire spd_ev = cmd_take & cmd_hit(rx_byte, ibrl_pkg::CMD_SPD);
  // parallel poll codes decode to nothing: no state, no output [R13]
  wire pp_ev = cmd_take & (cmd_hit(rx_byte, ibrl_pkg::CMD_PPC) |
                           cmd_hit(rx_byte, ibrl_pkg::CMD_PPU));

  wire clear_ev = dcl_ev | (sdc_ev & listen); // [R16]
  wire is_remote = (rl == ibrl_pkg::IBRL_REMOTE);
  wire local_key = key_valid & key_is_local & is_remote & ~lockout; // [R07]
  wire ren_rise = ren & ~ren_q;
  wire remote_req = ren & (mla_ev | (ren_rise & listen)); // [R01]

  ////////////////////////////////////////////////////////////////////////////////
  // remote enable false has top priority, then the two local requests
  always_comb begin
    next_rl = rl;
    if (!ren) begin
      next_rl = ibrl_pkg::IBRL_LOCAL; // [R05] [R09]
    end else if (gtl_ev || local_key) begin
      next_rl = ibrl_pkg::IBRL_LOCAL; // [R05] [R22]
    end else if (remote_req) begin
      next_rl = ibrl_pkg::IBRL_REMOTE; // [R01]
    end
  end

  // go-to-local never touches lockout; only remote enable false or reset clears it
  wire next_lockout = ren & (lockout | llo_ev); // [R08] [R09] [R22]
  wire next_listen = ~ifc & ~unl_ev & (listen | mla_ev); // [R20]
  wire next_talk = ~ifc & ~ota_ev & (talk | mta_ev); // [R20]
  wire next_spoll = ~ifc & ~spd_ev & (spoll | spe_ev);
  wire next_ctrl = ~ifc & (ctrl_active | (tct_ev & talk)); // [R19]
  wire [1:0] next_saved = (is_remote & trig_wr) ? trig_in : trig_saved;
  wire [1:0] next_trig = (next_rl == ibrl_pkg::IBRL_REMOTE) ? next_saved :
                         ibrl_pkg::TRIG_FULL_REPEAT; // [R04] [R06]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rl <= ibrl_pkg::IBRL_LOCAL; // [R24]
      lockout <= 1'b0;
      listen <= 1'b0;
      talk <= 1'b0;
      spoll <= 1'b0;
      ctrl_active <= 1'b0;
      ren_q <= 1'b0;
      trig_saved <= ibrl_pkg::TRIG_FULL_REPEAT;
      trig_cfg <= ibrl_pkg::TRIG_FULL_REPEAT;
    end else begin
      rl <= next_rl;
      lockout <= next_lockout;
      listen <= next_listen;
      talk <= next_talk;
      spoll <= next_spoll;
      ctrl_active <= next_ctrl;
      ren_q <= ren;
      trig_saved <= next_saved;
      trig_cfg <= next_trig;
    end
  end

  assign remote_ind = is_remote; // [R02]
  assign listen_ind = listen;
  assign talk_ind = talk;

  ////////////////////////////////////////////////////////////////////////////////
  // front panel, trigger and clear strobes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_pass <= 1'b0;
      meas_start <= 1'b0;
      dev_clear <= 1'b0;
      opc_idle <= ibrl_pkg::RESET_OPC_IDLE;
    end else begin
      key_pass <= key_valid & ~is_remote; // [R03]
      meas_start <= (get_ev | trg_cmd) & listen & is_remote; // [R17] [R18]
      // the instrument drops its message-available bit on this pulse; settings stay
      dev_clear <= clear_ev; // [R14] [R15]
      if (clear_ev) begin
        opc_idle <= 1'b1; // [R14]
      end else if (rx_valid && !atn && listen) begin
        opc_idle <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // listener data path; a full buffer holds the acceptor off instead of losing bytes
  ibrl_fifo #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .clk(ref_clk),
    .rst_n(rst_n),
    .flush(clear_ev), // [R14]
    .in_valid(rx_valid & ~atn & listen),
    .in_ready(buf_in_ready),
    .in_data(rx_byte),
    .out_valid(par_valid),
    .out_ready(par_ready),
    .out_data(par_byte)
  );

  // bytes not meant for us are taken and dropped
  assign rx_ready = atn | ~listen | buf_in_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // service request and talker path
  wire need = |(status & sre & ibrl_pkg::RQS_MASK); // [R10]
  wire [7:0] stb = (status & ibrl_pkg::RQS_MASK) | (rqs ? ibrl_pkg::RQS_BIT : 8'h00); // [R12]
  wire poll_mode = spoll & talk & ~atn;
  wire tx_taken = tx_valid & tx_ready;
  wire tx_free = ~tx_valid | tx_taken;
  wire poll_taken = tx_taken & tx_poll;
  // one idle cycle between status bytes so a cleared request bit is seen
  wire poll_load = poll_mode & ~tx_valid; // [R11]
  wire tx_drop = clear_ev | ifc | (tx_valid & tx_poll & ~poll_mode & ~tx_taken);
  wire resp_fwd = tx_free & talk & ~atn & ~spoll & ~tx_drop;
  assign resp_ready = resp_dashed | resp_fwd; // [R21]
  wire resp_load = resp_valid & ~resp_dashed & resp_fwd; // [R21]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      srq <= 1'b0;
      rqs <= 1'b0;
    end else begin
      srq <= need; // [R10]
      rqs <= srq | (rqs & ~poll_taken); // [R12]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      tx_poll <= 1'b0;
    end else if (tx_drop) begin
      tx_valid <= 1'b0; // [R14] [R20]
    end else if (poll_load) begin
      tx_byte <= stb; // [R11]
      tx_valid <= 1'b1;
      tx_poll <= 1'b1;
    end else if (resp_load) begin
      tx_byte <= resp_byte;
      tx_valid <= 1'b1;
      tx_poll <= 1'b0;
    end else if (tx_taken) begin
      tx_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  remote_entry_a: assert property (!is_remote && ren && mla_ev |=> remote_ind) // [R01]
    else $error("no remote entry on listen address with remote enable");
  ren_rise_a: assert property (ren && !ren_q && listen && !gtl_ev |=> remote_ind) // [R01]
    else $error("no remote entry on remote enable rising while listener");
  ren_drop_a: assert property (!ren |=> !remote_ind && !lockout) // [R09]
    else $error("remote enable false did not give local and clear lockout");
  gtl_local_a: assert property (gtl_ev |=> !remote_ind) // [R05]
    else $error("go-to-local did not give local");
  local_key_a: assert property (local_key |=> !remote_ind) // [R05]
    else $error("return-to-local key did not give local");
  lock_key_a: assert property (is_remote && lockout && ren && !gtl_ev |=> remote_ind) // [R07]
    else $error("return-to-local key worked under lockout");
  llo_set_a: assert property (llo_ev && ren |=> lockout) // [R08]
    else $error("lockout command did not set lockout");
  key_block_a: assert property (key_valid && remote_ind |=> !key_pass) // [R03]
    else $error("front-panel key passed in remote");
  key_local_a: assert property (key_valid && !remote_ind |=> key_pass) // [R03]
    else $error("front-panel key lost in local");
  srq_follow_a: assert property (need |=> srq ##1 stb[6]) // [R10]
    else $error("service request or request bit missing");
  srq_off_a: assert property (!need |=> !srq) // [R10]
    else $error("service request without an enabled status bit");
  poll_byte_a: assert property (poll_load && !tx_drop |=> tx_valid && tx_poll) // [R11]
    else $error("status byte not loaded in serial poll");
  poll_rqs_a: assert property (poll_load && !tx_drop |=> tx_byte[6] == $past(rqs)) // [R12]
    else $error("status byte bit 6 does not carry the request");
  rqs_clear_a: assert property (poll_taken && !srq |=> !stb[6]) // [R12]
    else $error("request bit kept after the polled status byte");
  // a byte on offer must stand until taken, or the controller reads a torn byte
  tx_hold_a: assert property (tx_valid && !tx_ready && !tx_drop // [R11]
                              |=> tx_valid && $stable(tx_byte))
    else $error("talker byte changed before it was taken");
  dashed_drop_a: assert property (resp_dashed && !tx_valid && !poll_load |=> !tx_valid) // [R21]
    else $error("dashed result was offered to the bus");
  trig_local_a: assert property (!remote_ind |-> trig_cfg == ibrl_pkg::TRIG_FULL_REPEAT) // [R06]
    else $error("trigger setup not forced in local");
  trig_keep_a: assert property (remote_ind |-> trig_cfg == trig_saved) // [R04]
    else $error("trigger setup in remote is not the one saved in remote");
  clear_flush_a: assert property (clear_ev |=> dev_clear && !par_valid && !tx_valid) // [R14]
    else $error("device clear did not flush");
  opc_clear_a: assert property (clear_ev |=> opc_idle) // [R14]
    else $error("device clear did not give the complete idle state");
  sdc_addr_a: assert property (sdc_ev && !listen |=> !dev_clear) // [R16]
    else $error("selected clear acted without listen address");
  meas_gate_a: assert property (meas_start |-> $past(remote_ind) && $past(listen)) // [R17]
    else $error("measurement started outside remote listener");
  meas_local_a: assert property (!remote_ind |=> !meas_start) // [R17]
    else $error("measurement started in local");
  tct_take_a: assert property (tct_ev && talk && !ifc |=> ctrl_active) // [R19]
    else $error("take control while talker was not taken");
  ifc_drop_a: assert property (ifc |=> !listen_ind && !talk_ind && !ctrl_active) // [R20]
    else $error("interface clear kept addressing");
  gtl_lock_a: assert property (gtl_ev && lockout && ren |=> !remote_ind && lockout) // [R22]
    else $error("go-to-local changed lockout");
  pp_quiet_a: assert property (pp_ev && !ifc |=> $stable(listen) && $stable(talk)) // [R13]
    else $error("parallel poll code changed addressing");

  remote_c: cover property (!remote_ind ##1 remote_ind);
  poll_c: cover property (poll_taken && stb[6] == 1'b0);
  clear_c: cover property (par_valid ##1 clear_ev);
  lock_c: cover property (lockout && key_valid && key_is_local && remote_ind);
  lock_gtl_c: cover property (gtl_ev && lockout);
endmodule // ibrl_msg_handler

// ==== rtl/ibrl_pkg.sv ====
// constants, codes and types of the instrument bus remote/local message handler
// Contract
// R01 - enter remote when remote enable is true and the device becomes addressed listener
// R02 - drive a remote indicator output while in remote state
// R03 - in remote, block every front-panel key except return-to-local
// R04 - entering remote keeps settings, restores last trigger setup programmed in remote
// R05 - leave remote on go-to-local, return-to-local key, or remote enable false
// R06 - back in local keep settings but force full settle with repeat retrigger
// R07 - while lockout is set ignore the return-to-local key
// R08 - lockout command sets lockout flag; only controller or power cycle clears it
// R09 - remote enable false returns to local and clears lockout
// R10 - assert service request while any enabled status byte bit is true
// R11 - after serial poll enable and talk addressing, return one 8-bit status byte
// R12 - status byte bit 6 is one when the device has been requesting service
// R13 - parallel poll configure, enable, disable, unconfigure and identify are ignored
// R14 - device clear flushes input and output, aborts commands, enters complete idle
// R15 - device clear keeps settings and status bits; only message-available clears
// R16 - universal clear and selected clear as listener act the same
// R17 - trigger command starts a measurement only in remote and addressed to listen
// R18 - bus group trigger and common trigger command are equivalent sources
// R19 - take control while addressed to talk makes the device active controller
// R20 - interface clear drops talker and listener addressing at once
// R21 - status, messages and valid results are readable; dashed results never sent
// R22 - go-to-local under lockout restores the panel but keeps the lockout flag
// R23 - bus primary address is configurable from 0 to 30, held across power cycles
// R24 - reset starts in local, lockout clear, unaddressed, service request off
package ibrl_pkg;
  // universal and addressed commands, compared on the low seven bits
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_PPC = 8'h05;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_TCT = 8'h09;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_PPU = 8'h15;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [1:0] TALK_GROUP = 2'h2;
  // address 31 is the unlisten/untalk code, so it never matches
  localparam logic [4:0] ADDR_NONE = 5'h1f;
  // trigger setup: bit0 fast settle, bit1 single retrigger
  localparam logic [1:0] TRIG_FULL_REPEAT = 2'h0;
  localparam logic [7:0] RQS_MASK = 8'hbf;
  localparam logic [7:0] RQS_BIT = 8'h40;
  localparam logic RESET_OPC_IDLE = 1'b1;
  typedef enum logic [0:0] {
    IBRL_LOCAL = 1'b0,
    IBRL_REMOTE = 1'b1
  } ibrl_rl_t;
endpackage

// ==== test/ibrl_bus_ctl.sv ====
// bus system controller model: remote enable, attention, interface clear and bytes
`timescale 1ns/10ps
module ibrl_bus_ctl (
  input wire logic ref_clk,
  input wire logic rx_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic ren,
  output logic atn,
  output logic ifc,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic tx_ready
);
  int n_err = 0;
  initial begin
    ren = 1'b0;
    atn = 1'b0;
    ifc = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one byte per handshake; data waits for the acceptor to be ready, as on the wire
  task automatic put(input logic a, input logic [7:0] b);
    int i;
    @(negedge ref_clk);
    atn = a;
    rx_byte = b;
    // ready is judged a cycle on, once it has settled on the new attention level
    for (i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      if (rx_ready === 1'b1) break;
    end
    if (i == 50) n_err++;
    rx_valid = 1'b1;
    @(negedge ref_clk);
    rx_valid = 1'b0;
    // released lines must not look like the last byte
    rx_byte = ~b;
  endtask
  task automatic get(output logic [7:0] b);
    int i;
    @(negedge ref_clk);
    atn = 1'b0;
    for (i = 0; i < 50 && tx_valid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 50) n_err++;
    b = tx_byte;
    tx_ready = 1'b1;
    @(negedge ref_clk);
    tx_ready = 1'b0;
  endtask
  // level lines: remote enable, attention and interface clear
  task automatic drive(input logic r, input logic a, input logic f);
    @(negedge ref_clk);
    ren = r;
    atn = a;
    ifc = f;
  endtask
  // poll enable first, then talk address, then one status byte
  task automatic poll(input logic [4:0] addr, output logic [7:0] b);
    put(1'b1, ibrl_pkg::CMD_SPE);
    put(1'b1, ibrl_pkg::TALK_BASE | {3'h0, addr});
    get(b);
    put(1'b1, ibrl_pkg::CMD_SPD);
  endtask
endmodule // ibrl_bus_ctl

// ==== test/test_instrument_bus_remote_local_msgs.sv ====
// self-checking bench for the bus remote/local message handler
`timescale 1ns/10ps
module test_instrument_bus_remote_local_msgs;
  localparam logic [7:0] MLA = ibrl_pkg::LISTEN_BASE | 8'h07;
  localparam logic [7:0] MTA = ibrl_pkg::TALK_BASE | 8'h07;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ren, atn, ifc, rx_valid, rx_ready, par_valid, tx_valid, tx_ready, resp_ready;
  logic [7:0] rx_byte, par_byte, tx_byte, sb;
  logic par_ready = 1'b0;
  logic resp_valid = 1'b0;
  logic resp_dashed = 1'b0;
  logic key_valid = 1'b0;
  logic key_is_local = 1'b0;
  logic trig_wr = 1'b0;
  logic trg_cmd = 1'b0;
  logic [7:0] resp_byte = 8'h00;
  logic [7:0] status = 8'h00;
  logic [7:0] sre = 8'h00;
  logic [1:0] trig_in = 2'h0;
  logic key_pass, meas_start, dev_clear, opc_idle, remote_ind, lockout, listen_ind;
  logic talk_ind, srq, ctrl_active;
  logic [1:0] trig_cfg;
  wire [7:0] st = {3'h0, ctrl_active, talk_ind, listen_ind, lockout, remote_ind};
  int n_fail = 0;
  int comparisons = 0;
  int n_meas = 0;
  int n_clr = 0;
  int n_key = 0;
  int m, k;
  ibrl_bus_ctl i_ctl (.ref_clk(ref_clk), .rx_ready(rx_ready), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .ren(ren), .atn(atn), .ifc(ifc), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .tx_ready(tx_ready));
  ibrl_msg_handler i_dut (.ref_clk(ref_clk), .nrst(nrst), .my_addr(5'h07), .ren(ren),
    .atn(atn), .ifc(ifc), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .par_byte(par_byte), .par_valid(par_valid), .par_ready(par_ready),
    .resp_byte(resp_byte), .resp_valid(resp_valid), .resp_dashed(resp_dashed),
    .resp_ready(resp_ready), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .status(status), .sre(sre), .key_valid(key_valid), .key_is_local(key_is_local),
    .key_pass(key_pass), .trig_wr(trig_wr), .trig_in(trig_in), .trg_cmd(trg_cmd),
    .trig_cfg(trig_cfg), .meas_start(meas_start), .dev_clear(dev_clear),
    .opc_idle(opc_idle), .remote_ind(remote_ind), .lockout(lockout),
    .listen_ind(listen_ind), .talk_ind(talk_ind), .srq(srq), .ctrl_active(ctrl_active));
  ////////////////////////////////////////////////////////////////////////////////
  // pulses are counted, so a doubled or missing pulse shows as a wrong delta
  always @(posedge ref_clk) begin
    if (meas_start === 1'b1) n_meas++;
    if (dev_clear === 1'b1) n_clr++;
    if (key_pass === 1'b1) n_key++;
    if (i_ctl.n_err != 0) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cmd(input logic [7:0] b);
    i_ctl.put(1'b1, b);
    tick(1);
  endtask
  task automatic key(input logic l);
    @(negedge ref_clk) key_valid = 1'b1;
    key_is_local = l;
    @(negedge ref_clk) key_valid = 1'b0;
    tick(2);
  endtask
  task automatic trg();
    @(negedge ref_clk) trg_cmd = 1'b1;
    @(negedge ref_clk) trg_cmd = 1'b0;
    tick(2);
  endtask
  task automatic resp(input logic [7:0] b, input logic d);
    int i;
    @(negedge ref_clk) resp_valid = 1'b1;
    resp_byte = b;
    resp_dashed = d;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (resp_ready === 1'b1) break;
    end
    if (i == 50) begin
      n_fail++;
      final_report();
    end else begin
      @(negedge ref_clk) resp_valid = 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_remote();
    i_ctl.drive(1'b1, 1'b1, 1'b0);
    cmd(MLA);
    chk(st, 8'h05);
    chk(trig_cfg, 2'h0);
    @(negedge ref_clk) trig_wr = 1'b1;
    trig_in = 2'h3;
    @(negedge ref_clk) trig_wr = 1'b0;
    tick(1);
    k = n_key;
    key(1'b0);
    chk(8'(n_key - k), 8'h00);
    key(1'b1);
    chk(st, 8'h04);
    chk(trig_cfg, 2'h0);
    k = n_key;
    key(1'b0);
    chk(8'(n_key - k), 8'h01);
    cmd(MLA);
    chk(trig_cfg, 2'h3);
    cmd(ibrl_pkg::CMD_GTL);
    chk(st, 8'h04);
    cmd(MLA);
    $display("test remote done");
  endtask
  task automatic t_lock();
    cmd(ibrl_pkg::CMD_LLO);
    chk(st, 8'h07);
    key(1'b1);
    chk(st, 8'h07);
    cmd(ibrl_pkg::CMD_GTL);
    chk(st, 8'h06);
    cmd(MLA);
    chk(st, 8'h07);
    i_ctl.drive(1'b0, 1'b1, 1'b0);
    tick(2);
    chk(st, 8'h04);
    i_ctl.drive(1'b1, 1'b1, 1'b0);
    tick(2);
    chk(st, 8'h05);
    $display("test lockout done");
  endtask
  task automatic t_trig();
    m = n_meas;
    cmd(ibrl_pkg::CMD_GET);
    trg();
    chk(8'(n_meas - m), 8'h02);
    cmd(ibrl_pkg::CMD_GTL);
    cmd(ibrl_pkg::CMD_GET);
    trg();
    chk(8'(n_meas - m), 8'h02);
    cmd(MLA);
    $display("test trigger done");
  endtask
  task automatic t_clear();
    i_ctl.put(1'b0, 8'ha1);
    i_ctl.put(1'b0, 8'ha2);
    tick(1);
    chk({6'h0, rx_ready, par_valid}, 8'h01);
    chk(par_byte, 8'ha1);
    @(negedge ref_clk) par_ready = 1'b1;
    @(negedge ref_clk);
    chk(par_byte, 8'ha2);
    @(negedge ref_clk) par_ready = 1'b0;
    chk({7'h0, par_valid}, 8'h00);
    i_ctl.put(1'b0, 8'ha3);
    m = n_clr;
    cmd(ibrl_pkg::CMD_DCL);
    chk({6'h0, par_valid, opc_idle}, 8'h01);
    cmd(ibrl_pkg::CMD_SDC);
    chk(8'(n_clr - m), 8'h02);
    chk({trig_cfg, st[5:0]}, 8'hc5);
    cmd(ibrl_pkg::CMD_PPC);
    cmd(ibrl_pkg::CMD_PPU);
    chk(8'(n_clr - m), 8'h02);
    chk(st, 8'h05);
    $display("test clear done");
  endtask
  task automatic t_poll();
    sre = 8'h10;
    status = 8'h01;
    tick(3);
    chk({7'h0, srq}, 8'h00);
    status = 8'h10;
    tick(3);
    chk({7'h0, srq}, 8'h01);
    status = 8'h40;
    sre = 8'hff;
    tick(3);
    chk({7'h0, srq}, 8'h00);
    i_ctl.poll(5'h07, sb);
    chk(sb, 8'h40);
    i_ctl.poll(5'h07, sb);
    chk(sb, 8'h00);
    $display("test poll done");
  endtask
  task automatic t_talk();
    i_ctl.drive(1'b1, 1'b0, 1'b0);
    resp(8'h2d, 1'b1);
    resp(8'h5a, 1'b0);
    i_ctl.get(sb);
    chk(sb, 8'h5a);
    tick(2);
    chk({7'h0, tx_valid}, 8'h00);
    cmd(MTA);
    cmd(ibrl_pkg::CMD_TCT);
    chk(st & 8'h18, 8'h18);
    i_ctl.drive(1'b1, 1'b1, 1'b1);
    i_ctl.drive(1'b1, 1'b1, 1'b0);
    tick(1);
    chk(st & 8'h1c, 8'h00);
    $display("test talker done");
  endtask
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  initial begin
    tick(3);
    nrst = 1'b1;
    tick(3);
    chk({st[5:0], srq, opc_idle}, 8'h01);
    t_remote();
    t_lock();
    t_trig();
    t_clear();
    t_poll();
    t_talk();
    final_report();
  end
endmodule // test_instrument_bus_remote_local_msgs
